// [hdl/slc_pkg.sv]
// Purpose: constants shared by the stack limit checker
// Assumes: 16-bit data addresses, byte addressed, word stack
// Notes: segment bounds are plain defaults
package slc_pkg;
    localparam int          SLC_AW           = 16;
    localparam int          SLC_PCW          = 23;
    localparam logic [15:0] SLC_SP_RESET     = 16'h0800;
    localparam logic [15:0] SLC_UNDER_BOUND  = 16'h0800;
    localparam logic [15:0] SLC_WORD_STEP    = 16'h0002;
    localparam int          SLC_PC_MSB_W     = 7;
    localparam logic [15:0] SLC_BRAM_LO      = 16'h0800;
    localparam logic [15:0] SLC_BRAM_HI      = 16'h08FF;
    localparam logic [15:0] SLC_SRAM_LO      = 16'h0900;
    localparam logic [15:0] SLC_SRAM_HI      = 16'h09FF;
    localparam logic [22:0] SLC_BFLASH_LO    = 23'h000200;
    localparam logic [22:0] SLC_BFLASH_HI    = 23'h0003FF;
    localparam logic [22:0] SLC_SFLASH_LO    = 23'h000400;
    localparam logic [22:0] SLC_SFLASH_HI    = 23'h0007FF;

    typedef enum logic [1:0] {
        SLC_OP_NONE = 2'b00,
        SLC_OP_PUSH = 2'b01,
        SLC_OP_POP  = 2'b10,
        SLC_OP_EA   = 2'b11
    } slc_op_e;

    typedef enum logic [1:0] {
        SLC_PUSH_DATA = 2'b00,
        SLC_PUSH_CALL = 2'b01,
        SLC_PUSH_EXC  = 2'b10
    } slc_push_e;
endpackage : slc_pkg

// [hdl/slc_seg_guard.sv]
// Purpose: secure RAM segment guard
// Assumes: code address is the executing program counter
// Notes: pure combinational decode
module slc_seg_guard (
    input  wire logic [15:0] data_addr,
    input  wire logic [22:0] code_addr,
    input  wire logic        boot_prot_en,
    input  wire logic        sec_prot_en,
    output logic             deny
);
    wire in_boot_ram  = (data_addr >= slc_pkg::SLC_BRAM_LO) && (data_addr <= slc_pkg::SLC_BRAM_HI);
    wire in_sec_ram   = (data_addr >= slc_pkg::SLC_SRAM_LO) && (data_addr <= slc_pkg::SLC_SRAM_HI);
    wire from_bflash  = (code_addr >= slc_pkg::SLC_BFLASH_LO) && (code_addr <= slc_pkg::SLC_BFLASH_HI);
    wire from_sflash  = (code_addr >= slc_pkg::SLC_SFLASH_LO) && (code_addr <= slc_pkg::SLC_SFLASH_HI);
    wire boot_deny    = boot_prot_en && in_boot_ram && !from_bflash;
    wire sec_deny     = sec_prot_en && in_sec_ram && !from_sflash;
    assign deny = boot_deny || sec_deny;
endmodule : slc_seg_guard

// [hdl/slc_stack_checker.sv]
// Purpose: stack pointer, stack limit and stack error trap logic
// Assumes: one operation per cycle from address generation
// Notes: limit register keeps no reset value by design

module slc_stack_checker (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [1:0]  op,
    input  wire logic [1:0]  push_kind,
    input  wire logic [15:0] push_data,
    input  wire logic [22:0] pc,
    input  wire logic [7:0]  status_low_byte,
    input  wire logic [15:0] effective_address,
    input  wire logic        ea_uses_sp,
    input  wire logic        sp_wr,
    input  wire logic [15:0] sp_wdata,
    input  wire logic        lim_wr,
    input  wire logic [15:0] lim_wdata,
    input  wire logic        boot_prot_en,
    input  wire logic        sec_prot_en,
    output logic [15:0]      stack_pointer_reg,
    output logic [15:0]      stack_limit_reg,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    output logic             mem_we,
    output logic             mem_re,
    output logic             stack_trap,
    output logic             ram_fault
);
    logic [15:0] next_sp;
    logic [15:0] lim_q;
    logic        deny;

    wire is_push = (op == slc_pkg::SLC_OP_PUSH);
    wire is_pop  = (op == slc_pkg::SLC_OP_POP);
    wire is_ea   = (op == slc_pkg::SLC_OP_EA) && ea_uses_sp;

    // pop address is the pointer after predecrement
    wire [15:0] sp_dec  = stack_pointer_reg - slc_pkg::SLC_WORD_STEP;
    wire [15:0] sp_inc  = stack_pointer_reg + slc_pkg::SLC_WORD_STEP;
    wire [15:0] chk_ea  = is_push ? stack_pointer_reg :
                          is_pop  ? sp_dec : effective_address;

    // equality passes; only an address beyond the limit traps, so the push
    // after the one at the limit is the one that fails
    wire over_err  = (is_push || is_ea) && (chk_ea > stack_limit_reg);
    wire under_err = (is_push || is_pop || is_ea) &&
                     (chk_ea < slc_pkg::SLC_UNDER_BOUND);
    wire trap_now  = over_err || under_err;

    wire [6:0]  pc_msb    = pc[22:16];
    wire [15:0] call_word = {9'h000, pc_msb};
    wire [15:0] exc_word  = {status_low_byte, 1'b0, pc_msb};
    wire [15:0] push_word = (push_kind == slc_pkg::SLC_PUSH_CALL) ? call_word :
                            (push_kind == slc_pkg::SLC_PUSH_EXC)  ? exc_word  : push_data;

    slc_seg_guard u_guard (
        .data_addr    (chk_ea),
        .code_addr    (pc),
        .boot_prot_en (boot_prot_en),
        .sec_prot_en  (sec_prot_en),
        .deny         (deny)
    );

    wire access  = is_push || is_pop || is_ea;
    wire blocked = trap_now || (access && deny);

    // trap cancels the pointer update as well as the access
    always_comb begin
        next_sp = stack_pointer_reg;
        if (sp_wr) begin
            next_sp = sp_wdata;
        end else if (is_push && !blocked) begin
            next_sp = sp_inc;
        end else if (is_pop && !blocked) begin
            next_sp = sp_dec;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stack_pointer_reg <= slc_pkg::SLC_SP_RESET;
        end else begin
            stack_pointer_reg <= next_sp;
        end
    end

    // no reset branch: content is undefined until software writes it
    always_ff @(posedge sys_clk) begin
        if (lim_wr) begin
            lim_q <= {lim_wdata[15:1], 1'b0};
        end
    end
    assign stack_limit_reg = lim_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mem_addr   <= 16'h0000;
            mem_wdata  <= 16'h0000;
            mem_we     <= 1'b0;
            mem_re     <= 1'b0;
            stack_trap <= 1'b0;
            ram_fault  <= 1'b0;
        end else begin
            mem_addr   <= chk_ea;
            mem_wdata  <= push_word;
            mem_we     <= is_push && !blocked;
            mem_re     <= (is_pop || is_ea) && !blocked;
            stack_trap <= trap_now;
            ram_fault  <= access && deny && !trap_now;
        end
    end

    property p_push_no_trap_at_limit;
        @(posedge sys_clk) disable iff (!rstn)
        (is_push && stack_pointer_reg == stack_limit_reg && !sp_wr && !lim_wr
            && stack_pointer_reg >= slc_pkg::SLC_UNDER_BOUND && !deny)
            |=> (!stack_trap && mem_we);
    endproperty
    a_push_no_trap_at_limit: assert property (p_push_no_trap_at_limit)
        else $error("push at limit trapped");

    sequence s_push_at_limit;
        is_push && !blocked && stack_pointer_reg == stack_limit_reg && !sp_wr && !lim_wr;
    endsequence
    sequence s_next_push;
        is_push && !sp_wr && !lim_wr;
    endsequence
    property p_overflow_next_push;
        @(posedge sys_clk) disable iff (!rstn)
        s_push_at_limit ##1 s_next_push |=> (stack_trap && !mem_we);
    endproperty
    a_overflow_next_push: assert property (p_overflow_next_push)
        else $error("overflow push did not trap");

    property p_underflow;
        @(posedge sys_clk) disable iff (!rstn)
        (access && chk_ea < slc_pkg::SLC_UNDER_BOUND) |=> stack_trap;
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow not trapped");

    property p_push_increments;
        @(posedge sys_clk) disable iff (!rstn)
        (is_push && !blocked && !sp_wr) |=>
            (stack_pointer_reg == $past(stack_pointer_reg) + slc_pkg::SLC_WORD_STEP)
            && mem_addr == $past(stack_pointer_reg);
    endproperty
    a_push_increments: assert property (p_push_increments)
        else $error("push pointer update wrong");

    property p_pop_predec;
        @(posedge sys_clk) disable iff (!rstn)
        (is_pop && !blocked && !sp_wr) |=> (mem_re && mem_addr == stack_pointer_reg);
    endproperty
    a_pop_predec: assert property (p_pop_predec)
        else $error("pop address not predecremented");

    property p_call_msb_clear;
        @(posedge sys_clk) disable iff (!rstn)
        (is_push && push_kind == slc_pkg::SLC_PUSH_CALL) |=> (mem_wdata[15:7] == 9'h000);
    endproperty
    a_call_msb_clear: assert property (p_call_msb_clear)
        else $error("call push upper bits not clear");

    property p_exc_srl;
        @(posedge sys_clk) disable iff (!rstn)
        (is_push && push_kind == slc_pkg::SLC_PUSH_EXC) |=> (mem_wdata[15:8] == $past(status_low_byte));
    endproperty
    a_exc_srl: assert property (p_exc_srl)
        else $error("exception push lacks status byte");

    property p_limit_aligned;
        @(posedge sys_clk) disable iff (!rstn)
        $past(lim_wr) |-> (stack_limit_reg[0] == 1'b0 && stack_limit_reg[15:1] == $past(lim_wdata[15:1]));
    endproperty
    a_limit_aligned: assert property (p_limit_aligned)
        else $error("limit not word aligned");

    property p_trap_single;
        @(posedge sys_clk) disable iff (!rstn)
        stack_trap |-> (!mem_we && !mem_re);
    endproperty
    a_trap_single: assert property (p_trap_single)
        else $error("trapped access not cancelled");

    property p_seg_deny;
        @(posedge sys_clk) disable iff (!rstn)
        ram_fault |-> (!mem_we && !mem_re);
    endproperty
    a_seg_deny: assert property (p_seg_deny)
        else $error("protected segment accessed");

    property p_ea_over_trap;
        @(posedge sys_clk) disable iff (!rstn)
        (is_ea && effective_address > stack_limit_reg) |=> (stack_trap && !mem_re);
    endproperty
    a_ea_over_trap: assert property (p_ea_over_trap)
        else $error("pointer address beyond limit not trapped");

    property p_ea_not_sp_free;
        @(posedge sys_clk) disable iff (!rstn)
        (op == slc_pkg::SLC_OP_EA && !ea_uses_sp) |=> (!stack_trap && !ram_fault);
    endproperty
    a_ea_not_sp_free: assert property (p_ea_not_sp_free)
        else $error("non-pointer address was checked");

    property p_pop_only_under;
        @(posedge sys_clk) disable iff (!rstn)
        (is_pop && sp_dec >= slc_pkg::SLC_UNDER_BOUND) |=> !stack_trap;
    endproperty
    a_pop_only_under: assert property (p_pop_only_under)
        else $error("pop above lower bound trapped");

    property p_sp_write_wins;
        @(posedge sys_clk) disable iff (!rstn)
        sp_wr |=> (stack_pointer_reg == $past(sp_wdata));
    endproperty
    a_sp_write_wins: assert property (p_sp_write_wins)
        else $error("pointer write lost");

    property p_call_pc_part;
        @(posedge sys_clk) disable iff (!rstn)
        (is_push && push_kind == slc_pkg::SLC_PUSH_CALL) |=> (mem_wdata[6:0] == $past(pc[22:16]));
    endproperty
    a_call_pc_part: assert property (p_call_pc_part)
        else $error("call push lacks counter upper part");

    property p_exc_pc_part;
        @(posedge sys_clk) disable iff (!rstn)
        (is_push && push_kind == slc_pkg::SLC_PUSH_EXC) |=>
            (mem_wdata[7] == 1'b0 && mem_wdata[6:0] == $past(pc[22:16]));
    endproperty
    a_exc_pc_part: assert property (p_exc_pc_part)
        else $error("exception push lacks counter upper part");

    property p_push_data_word;
        @(posedge sys_clk) disable iff (!rstn)
        (is_push && push_kind == slc_pkg::SLC_PUSH_DATA) |=> (mem_wdata == $past(push_data));
    endproperty
    a_push_data_word: assert property (p_push_data_word)
        else $error("data push word wrong");

    // an unwritten limit has no known bit zero, so it never qualifies
    property p_limit_hold;
        @(posedge sys_clk) disable iff (!rstn)
        (!lim_wr && stack_limit_reg[0] == 1'b0) |=> $stable(stack_limit_reg);
    endproperty
    a_limit_hold: assert property (p_limit_hold)
        else $error("limit changed without a write");

    sequence s_push_ok;
        is_push && !blocked && !sp_wr;
    endsequence
    sequence s_pop_ok;
        is_pop && !blocked && !sp_wr;
    endsequence
    property p_push_pop_same_word;
        @(posedge sys_clk) disable iff (!rstn)
        s_push_ok ##1 s_pop_ok |=> (mem_re && mem_addr == $past(mem_addr));
    endproperty
    a_push_pop_same_word: assert property (p_push_pop_same_word)
        else $error("pop did not return the pushed word address");

    property p_boot_ram_guard;
        @(posedge sys_clk) disable iff (!rstn)
        (access && !trap_now && boot_prot_en
            && chk_ea >= slc_pkg::SLC_BRAM_LO && chk_ea <= slc_pkg::SLC_BRAM_HI
            && !(pc >= slc_pkg::SLC_BFLASH_LO && pc <= slc_pkg::SLC_BFLASH_HI))
            |=> (ram_fault && !mem_we && !mem_re);
    endproperty
    a_boot_ram_guard: assert property (p_boot_ram_guard)
        else $error("boot secure RAM reached from outside boot code");

    property p_sec_ram_guard;
        @(posedge sys_clk) disable iff (!rstn)
        (access && !trap_now && sec_prot_en
            && chk_ea >= slc_pkg::SLC_SRAM_LO && chk_ea <= slc_pkg::SLC_SRAM_HI
            && !(pc >= slc_pkg::SLC_SFLASH_LO && pc <= slc_pkg::SLC_SFLASH_HI))
            |=> (ram_fault && !mem_we && !mem_re);
    endproperty
    a_sec_ram_guard: assert property (p_sec_ram_guard)
        else $error("secure RAM reached from outside secure code");

    property p_fault_needs_enable;
        @(posedge sys_clk) disable iff (!rstn)
        ram_fault |-> $past(boot_prot_en || sec_prot_en);
    endproperty
    a_fault_needs_enable: assert property (p_fault_needs_enable)
        else $error("segment fault without protection enabled");

    property p_no_op_quiet;
        @(posedge sys_clk) disable iff (!rstn)
        (op == slc_pkg::SLC_OP_NONE) |=> (!mem_we && !mem_re && !stack_trap && !ram_fault);
    endproperty
    a_no_op_quiet: assert property (p_no_op_quiet)
        else $error("strobe without an operation");

    property p_trap_keeps_sp;
        @(posedge sys_clk) disable iff (!rstn)
        (trap_now && !sp_wr) |=> (stack_trap && $stable(stack_pointer_reg));
    endproperty
    a_trap_keeps_sp: assert property (p_trap_keeps_sp)
        else $error("trapped operation moved the pointer");
endmodule : slc_stack_checker

// [testbench/slc_mem_model.sv]
// Purpose: data memory at the far side of the stack checker
// Assumes: word writes, one-cycle write strobe
// Notes: counts writes so a cancelled push shows up
module slc_mem_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_we,
    output int               wr_count,
    output logic [15:0]      last_word
);
    timeunit 1ns;
    timeprecision 1ps;
    initial wr_count = 0;
    always @(posedge sys_clk) begin
        if (mem_we === 1'b1) begin
            wr_count  <= wr_count + 1;
            last_word <= mem_wdata;
        end
    end
endmodule : slc_mem_model

// [testbench/slc_stack_checker_tb.sv]
// Purpose: self-checking bench for the stack checker
// Assumes: one op per cycle, inputs driven on the falling edge
// Notes: strobes are judged one cycle after the op edge
module slc_stack_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0, rstn = 1'b0, ea_uses_sp = 1'b0, sp_wr = 1'b0, lim_wr = 1'b0;
    logic        boot_prot_en = 1'b0, sec_prot_en = 1'b0;
    logic [1:0]  op = 2'h0, push_kind = 2'h0;
    logic [15:0] push_data = 16'h0000, effective_address = 16'h0000, sp_wdata = 16'h0000, lim_wdata = 16'h0000;
    logic [22:0] pc = 23'h000000;
    logic [7:0]  status_low_byte = 8'h00;
    logic [15:0] stack_pointer_reg, stack_limit_reg, mem_addr, mem_wdata, last_word;
    logic        mem_we, mem_re, stack_trap, ram_fault;
    int          wr_count, n, bad_count = 0, n_tests = 0, cycles = 0;

    slc_stack_checker uut (.sys_clk, .rstn, .op, .push_kind, .push_data, .pc, .status_low_byte,
        .effective_address, .ea_uses_sp, .sp_wr, .sp_wdata, .lim_wr, .lim_wdata, .boot_prot_en,
        .sec_prot_en, .stack_pointer_reg, .stack_limit_reg, .mem_addr, .mem_wdata, .mem_we,
        .mem_re, .stack_trap, .ram_fault);
    slc_mem_model mem (.sys_clk, .mem_wdata, .mem_we, .wr_count, .last_word);

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic cyc();
        @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : cyc
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16
    task automatic chk1(input string what, input logic exp, input logic got);
        chk16(what, {15'h0000, exp}, {15'h0000, got});
    endtask : chk1
    task automatic result(input logic we, input logic re, input logic trap, input logic flt, input logic [15:0] sp);
        chk1("mem_we", we, mem_we);
        chk1("mem_re", re, mem_re);
        chk1("stack_trap", trap, stack_trap);
        chk1("ram_fault", flt, ram_fault);
        chk16("stack_pointer_reg", sp, stack_pointer_reg);
    endtask : result
    task automatic push(input logic [1:0] kind, input logic [15:0] data);
        op = slc_pkg::SLC_OP_PUSH;
        push_kind = kind;
        push_data = data;
        cyc();
    endtask : push
    task automatic pop_or_ea(input logic [1:0] o, input logic [15:0] ea, input logic uses);
        op = o;
        effective_address = ea;
        ea_uses_sp = uses;
        cyc();
    endtask : pop_or_ea
    task automatic set_reg(input logic lim, input logic [15:0] v);
        op = slc_pkg::SLC_OP_NONE;
        lim_wr = lim;
        sp_wr = !lim;
        lim_wdata = v;
        sp_wdata = v;
        cyc();
        lim_wr = 1'b0;
        sp_wr = 1'b0;
        cyc();
    endtask : set_reg
    task automatic t_basic();
        chk16("stack_pointer_reg", 16'h0800, stack_pointer_reg);
        chk1("stack_trap", 1'b0, stack_trap);
        set_reg(1'b1, 16'h0A05);
        chk16("stack_limit_reg", 16'h0A04, stack_limit_reg);
        push(slc_pkg::SLC_PUSH_DATA, 16'h1234);
        result(1'b1, 1'b0, 1'b0, 1'b0, 16'h0802);
        chk16("mem_addr", 16'h0800, mem_addr);
        chk16("mem_wdata", 16'h1234, mem_wdata);
        pop_or_ea(slc_pkg::SLC_OP_POP, 16'h0000, 1'b0);
        result(1'b0, 1'b1, 1'b0, 1'b0, 16'h0800);
        chk16("mem_addr", 16'h0800, mem_addr);
        pop_or_ea(slc_pkg::SLC_OP_POP, 16'h0000, 1'b0);
        result(1'b0, 1'b0, 1'b1, 1'b0, 16'h0800);
        $display("test push pop done");
    endtask : t_basic
    task automatic t_pc_push();
        pc = 23'h4A1234;
        status_low_byte = 8'hC3;
        push(slc_pkg::SLC_PUSH_CALL, 16'hFFFF);
        result(1'b1, 1'b0, 1'b0, 1'b0, 16'h0802);
        chk16("mem_wdata", 16'h004A, mem_wdata);
        push(slc_pkg::SLC_PUSH_EXC, 16'hFFFF);
        chk16("mem_wdata", 16'hC34A, mem_wdata);
        chk16("mem_addr", 16'h0802, mem_addr);
        $display("test pc push done");
    endtask : t_pc_push
    task automatic t_limit();
        set_reg(1'b0, 16'h0A04);
        push(slc_pkg::SLC_PUSH_DATA, 16'h5555);
        result(1'b1, 1'b0, 1'b0, 1'b0, 16'h0A06);
        push(slc_pkg::SLC_PUSH_DATA, 16'hAAAA);
        result(1'b0, 1'b0, 1'b1, 1'b0, 16'h0A06);
        n = wr_count;
        op = slc_pkg::SLC_OP_NONE;
        cyc();
        chk16("wr_count", n[15:0], wr_count[15:0]);
        chk16("last_word", 16'h5555, last_word);
        pop_or_ea(slc_pkg::SLC_OP_EA, 16'h0A06, 1'b1);
        chk1("stack_trap", 1'b1, stack_trap);
        pop_or_ea(slc_pkg::SLC_OP_EA, 16'h0A04, 1'b1);
        chk1("stack_trap", 1'b0, stack_trap);
        pop_or_ea(slc_pkg::SLC_OP_EA, 16'h0A06, 1'b0);
        chk1("stack_trap", 1'b0, stack_trap);
        pop_or_ea(slc_pkg::SLC_OP_EA, 16'h07FE, 1'b1);
        chk1("stack_trap", 1'b1, stack_trap);
        $display("test limit done");
    endtask : t_limit
    task automatic t_segment();
        set_reg(1'b0, 16'h0800);
        boot_prot_en = 1'b1;
        pc = 23'h000100;
        push(slc_pkg::SLC_PUSH_DATA, 16'h0101);
        result(1'b0, 1'b0, 1'b0, 1'b1, 16'h0800);
        pc = 23'h000300;
        push(slc_pkg::SLC_PUSH_DATA, 16'h0202);
        result(1'b1, 1'b0, 1'b0, 1'b0, 16'h0802);
        set_reg(1'b0, 16'h0900);
        sec_prot_en = 1'b1;
        push(slc_pkg::SLC_PUSH_DATA, 16'h0303);
        result(1'b0, 1'b0, 1'b0, 1'b1, 16'h0900);
        pc = 23'h000500;
        push(slc_pkg::SLC_PUSH_DATA, 16'h0404);
        result(1'b1, 1'b0, 1'b0, 1'b0, 16'h0902);
        $display("test segment done");
    endtask : t_segment
    task automatic t_reset();
        op = slc_pkg::SLC_OP_NONE;
        boot_prot_en = 1'b0;
        sec_prot_en = 1'b0;
        rstn = 1'b0;
        cyc();
        result(1'b0, 1'b0, 1'b0, 1'b0, 16'h0800);
        chk16("stack_limit_reg", 16'h0A04, stack_limit_reg);
        rstn = 1'b1;
        push(slc_pkg::SLC_PUSH_DATA, 16'h7777);
        result(1'b1, 1'b0, 1'b0, 1'b0, 16'h0802);
        chk16("mem_addr", 16'h0800, mem_addr);
        chk16("stack_limit_reg", 16'h0A04, stack_limit_reg);
        $display("test reset done");
    endtask : t_reset
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // hang guard, tests need well under 200 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        t_basic();
        t_pc_push();
        t_limit();
        t_segment();
        t_reset();
        report_and_stop();
    end
endmodule : slc_stack_checker_tb
